//--- pkg/elc_pkg.sv
// package for the exterior lamp check sequencer: register map, lamp fields, timing
package elc_pkg;
    // ************************************************************
    // bus and register map
    // ************************************************************
    localparam int unsigned addr_w = 8;
    localparam logic [addr_w-1:0] ctrl_off = 8'h00;
    localparam logic [addr_w-1:0] dwell_off = 8'h04;
    localparam logic [addr_w-1:0] status_off = 8'h08;
    localparam logic [1:0] resp_okay = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;
    // ctrl bits
    localparam int unsigned ctrl_enable_bit = 0;
    localparam int unsigned ctrl_buttonless_bit = 1;
    localparam int unsigned ctrl_plow_bit = 2;
    localparam int unsigned ctrl_fog_bit = 3;
    localparam logic [3:0] ctrl_reset_val = 4'h1;
    // ************************************************************
    // timing
    // ************************************************************
    localparam longint unsigned clk_hz = 20000000;
    localparam longint unsigned second_s = 1;
    localparam longint unsigned second_cycles = second_s * clk_hz;
    localparam logic [3:0] dwell_default = 4'h2;
    localparam logic [3:0] dwell_min = 4'h1;
    localparam logic [3:0] dwell_max = 4'ha;
    // ************************************************************
    // lamp outputs and steps
    // ************************************************************
    typedef struct packed {
        logic plow_high;
        logic plow_low;
        logic high_beam;
        logic low_beam;
        logic fog;
        logic park;
        logic turn_right;
        logic turn_left;
        logic brake;
    } elc_lamps_type;
    localparam logic [3:0] step_first = 4'h0;
    localparam logic [3:0] step_fog = 4'h2;
    localparam logic [3:0] step_plow_low = 4'h3;
    localparam logic [3:0] step_last = 4'h9;
    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_armed = 2'b01,
        st_braked = 2'b10,
        st_run = 2'b11
    } elc_state_type;
endpackage : elc_pkg

//--- rtl/elc_sequencer.sv
// exterior lamp check sequencer with an axi4-lite register port
//
// The register offsets and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module elc_sequencer #(
    parameter longint unsigned second_count = elc_pkg::second_cycles
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [elc_pkg::addr_w-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [elc_pkg::addr_w-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic key_ign_acc,
    input wire logic key_off_crank,
    input wire logic park_brake_set,
    input wire logic service_brake,
    input wire logic cruise_on,
    input wire logic cruise_resume,
    input wire logic lamp_check_button,
    input wire logic lamp_switch_any_on,
    input wire logic inputs_status_good,
    input wire logic cruise_status_good,
    output elc_pkg::elc_lamps_type lamp_force,
    output logic lamp_check_active
);
    import elc_pkg::*;

    // ************************************************************
    // register port
    // ************************************************************
    logic [3:0] ctrl_q;
    logic [3:0] dwell_q;
    logic [31:0] status_w;
    logic aw_have_q;
    logic w_have_q;
    logic [addr_w-1:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic [3:0] step_q;
    elc_state_type state_q;
    logic aborts_q;

    assign status_w = {24'h0, aborts_q, 1'b0, state_q, step_q};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_addr_q <= '0;
            w_data_q <= '0;
            w_strb_q <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= resp_okay;
        end else begin
            s_axi_awready <= !aw_have_q && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_have_q && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (aw_have_q && w_have_q && !s_axi_bvalid) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr_q == ctrl_off || aw_addr_q == dwell_off)
                    ? resp_okay : resp_slverr;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
            end
        end
    end

    // register writes happen once, when the response is raised
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= ctrl_reset_val;
            dwell_q <= dwell_default;
        end else if (aw_have_q && w_have_q && !s_axi_bvalid && w_strb_q[0]) begin
            if (aw_addr_q == ctrl_off) begin
                ctrl_q <= w_data_q[3:0];
            end
            // out-of-range dwell is clamped rather than refused
            if (aw_addr_q == dwell_off) begin
                if (w_data_q[3:0] < dwell_min) begin
                    dwell_q <= dwell_min;
                end else if (w_data_q[3:0] > dwell_max || w_data_q[31:4] != 28'h0) begin
                    dwell_q <= dwell_max;
                end else begin
                    dwell_q <= w_data_q[3:0];
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= resp_okay;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= resp_okay;
                unique case (s_axi_araddr)
                    ctrl_off: s_axi_rdata <= {28'h0, ctrl_q};
                    dwell_off: s_axi_rdata <= {28'h0, dwell_q};
                    status_off: s_axi_rdata <= status_w;
                    default: begin
                        s_axi_rdata <= '0;
                        s_axi_rresp <= resp_slverr;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ************************************************************
    // entry and exit conditions
    // ************************************************************
    logic entry_ok;
    logic exit_now;
    logic cruise_pair;
    logic brake_prev_q;

    // cruise status only gates entry; it is not an exit cause
    assign entry_ok = ctrl_q[ctrl_enable_bit] && key_ign_acc && !key_off_crank
        && !lamp_switch_any_on && inputs_status_good && cruise_status_good
        && park_brake_set;
    assign exit_now = service_brake
        || lamp_switch_any_on
        || key_off_crank || !key_ign_acc || !park_brake_set
        || !inputs_status_good
        || !ctrl_q[ctrl_enable_bit];
    assign cruise_pair = cruise_on && cruise_resume;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            brake_prev_q <= 1'b0;
        end else begin
            brake_prev_q <= service_brake;
        end
    end

    // ************************************************************
    // sequencer state and timing
    // ************************************************************
    logic [$clog2(second_count+1)-1:0] sec_cnt_q;
    logic [3:0] dwell_left_q;
    logic sec_tick;
    logic step_done;
    logic [3:0] step_next;

    assign sec_tick = (sec_cnt_q == ($clog2(second_count+1))'(second_count - 1));
    assign step_done = sec_tick && (dwell_left_q == dwell_min);

    // plow and fog steps drop out of the list when not fitted
    always_comb begin
        step_next = (step_q == step_last) ? step_first : step_q + 4'h1;
        for (int i = 0; i < 3; i++) begin
            if ((step_next == step_first || step_next == step_plow_low)
                && !ctrl_q[ctrl_plow_bit]) begin
                step_next = step_next + 4'h1;
            end else if (step_next == step_fog && !ctrl_q[ctrl_fog_bit]) begin
                step_next = step_next + 4'h1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= st_idle;
            aborts_q <= 1'b0;
        end else begin
            unique case (state_q)
                st_idle: begin
                    if (entry_ok && !ctrl_q[ctrl_buttonless_bit] && lamp_check_button) begin
                        state_q <= st_run;
                    end else if (entry_ok && ctrl_q[ctrl_buttonless_bit] && cruise_pair) begin
                        state_q <= st_armed;
                    end
                end
                st_armed: begin
                    if (!entry_ok && !service_brake) begin
                        state_q <= st_idle;
                    end else if (service_brake && !brake_prev_q) begin
                        state_q <= st_braked;
                    end
                end
                st_braked: begin
                    if (!park_brake_set || !key_ign_acc || key_off_crank
                        || lamp_switch_any_on || !inputs_status_good) begin
                        state_q <= st_idle;
                    end else if (!service_brake) begin
                        state_q <= st_run;
                    end
                end
                st_run: begin
                    if (exit_now) begin
                        state_q <= st_idle;
                        aborts_q <= 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            step_q <= step_first;
            sec_cnt_q <= '0;
            dwell_left_q <= dwell_default;
        end else if (state_q != st_run || exit_now) begin
            step_q <= step_next_first();
            sec_cnt_q <= '0;
            dwell_left_q <= dwell_q;
        end else begin
            sec_cnt_q <= sec_tick ? '0 : sec_cnt_q + 1'b1;
            if (step_done) begin
                step_q <= step_next;
                dwell_left_q <= dwell_q;
            end else if (sec_tick) begin
                dwell_left_q <= dwell_left_q - 4'h1;
            end
        end
    end

    function automatic logic [3:0] step_next_first();
        logic [3:0] s;
        s = step_first;
        if (!ctrl_q[ctrl_plow_bit]) begin
            s = s + 4'h1;
        end
        return s;
    endfunction : step_next_first

    // ************************************************************
    // lamp outputs
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lamp_force <= '0;
            lamp_check_active <= 1'b0;
        end else if (state_q != st_run || exit_now) begin
            lamp_force <= '0;
            lamp_check_active <= 1'b0;
        end else begin
            lamp_check_active <= 1'b1;
            lamp_force <= '0; // no backup lamp field exists
            unique case (step_q)
                4'h0: lamp_force.plow_high <= 1'b1;
                4'h1: begin
                    lamp_force.high_beam <= 1'b1;
                    lamp_force.park <= 1'b1;
                end
                4'h2: begin
                    lamp_force.fog <= 1'b1;
                    lamp_force.park <= 1'b1;
                end
                4'h3: lamp_force.plow_low <= 1'b1;
                4'h4: begin
                    lamp_force.low_beam <= 1'b1;
                    lamp_force.park <= 1'b1;
                end
                4'h5: begin
                    lamp_force.turn_right <= 1'b1;
                    lamp_force.park <= 1'b1;
                end
                4'h6: begin
                    lamp_force.turn_left <= 1'b1;
                    lamp_force.park <= 1'b1;
                    lamp_force.brake <= 1'b1;
                end
                4'h8: lamp_force.brake <= 1'b1;
                default: lamp_force <= '0; // steps 7 and 9
            endcase
        end
    end
endmodule : elc_sequencer

`default_nettype wire

//--- verification/elc_seq_sva.sv
// assertion checker for the exterior lamp check sequencer
`timescale 1ns/1ps
`default_nettype none
module elc_seq_chk (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic key_ign_acc,
    input wire logic key_off_crank,
    input wire logic park_brake_set,
    input wire logic service_brake,
    input wire logic lamp_switch_any_on,
    input wire logic inputs_status_good,
    input wire elc_pkg::elc_lamps_type lamp_force,
    input wire logic lamp_check_active
);
    import elc_pkg::*;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ************************************************************
    // sequences
    // ************************************************************
    sequence s_calm;
        key_ign_acc && !key_off_crank && park_brake_set && !service_brake
            && !lamp_switch_any_on && inputs_status_good;
    endsequence
    sequence s_dark;
        lamp_force == '0 && !lamp_check_active;
    endsequence
    // ************************************************************
    // properties
    // ************************************************************
    brake_abort_a: assert property (lamp_check_active && service_brake |=> s_dark)
        else $error("check kept running after service brake");
    switch_abort_a: assert property (lamp_check_active && lamp_switch_any_on |=> s_dark)
        else $error("check kept running after lamp switch on");
    key_park_abort_a: assert property (
        lamp_check_active && (key_off_crank || !park_brake_set) |=> s_dark)
        else $error("check kept running after key or park exit");
    bad_status_a: assert property (lamp_check_active && !inputs_status_good |=> s_dark)
        else $error("check kept running on bad status");
    keep_cycling_a: assert property (lamp_check_active ##0 s_calm |=> lamp_check_active)
        else $error("check stopped without an exit condition");
    start_guard_a: assert property ($rose(lamp_check_active) |->
        $past(park_brake_set, 2) && $past(key_ign_acc, 2) && $past(inputs_status_good, 2))
        else $error("check started without entry conditions");
    left_turn_a: assert property (lamp_force.turn_left |->
        lamp_force.brake && lamp_force.park && !lamp_force.turn_right)
        else $error("left turn step lamps wrong");
    park_pair_a: assert property (
        lamp_force.high_beam || lamp_force.low_beam
        || lamp_force.fog || lamp_force.turn_right |-> lamp_force.park)
        else $error("park lights missing in a step");
    idle_dark_a: assert property (!lamp_check_active |-> lamp_force == '0)
        else $error("lamps forced while idle");
endmodule : elc_seq_chk
bind elc_sequencer elc_seq_chk u_chk (.aclk, .aresetn, .key_ign_acc, .key_off_crank,
    .park_brake_set, .service_brake, .lamp_switch_any_on, .inputs_status_good,
    .lamp_force, .lamp_check_active);
`default_nettype wire

//--- verification/elc_sequencer_tb_top.sv
// self-checking bench for the exterior lamp check sequencer
`timescale 1ns/1ps
`default_nettype none
module elc_sequencer_tb_top;
    import elc_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = '0;
    logic [7:0] s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire logic [1:0] s_axi_bresp, s_axi_rresp;
    wire logic [31:0] s_axi_rdata;
    wire logic key_ign_acc, key_off_crank, park_brake_set, service_brake, cruise_on;
    wire logic cruise_resume, lamp_check_button, lamp_switch_any_on;
    wire logic inputs_status_good, cruise_status_good;
    elc_lamps_type lamp_force;
    logic lamp_check_active;
    int n_fail = 0;
    int compares = 0;
    logic [1:0] r;
    logic [31:0] d;
    logic [3:0] cfg [5] = '{4'hd, 4'h1, 4'h5, 4'h9, 4'hf};
    // exits: service brake, lamp on, key off, park released, bad status
    logic [9:0] ex [5] = '{10'h2c3, 10'h287, 10'h183, 10'h203, 10'h281};
    logic [9:0] bad [5] = '{10'h08b, 10'h20b, 10'h28f, 10'h289, 10'h28a};
    initial forever #25 aclk = ~aclk;
    elc_sequencer #(.second_count(10)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .key_ign_acc, .key_off_crank, .park_brake_set, .service_brake, .cruise_on,
        .cruise_resume, .lamp_check_button, .lamp_switch_any_on, .inputs_status_good,
        .cruise_status_good, .lamp_force, .lamp_check_active);
    elc_vehicle_model veh (.aclk, .key_ign_acc, .key_off_crank, .park_brake_set,
        .service_brake, .cruise_on, .cruise_resume, .lamp_check_button,
        .lamp_switch_any_on, .inputs_status_good, .cruise_status_good);
    // ************************************************************
    // helpers
    // ************************************************************
    task automatic give_verdict();
        if (n_fail == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : give_verdict
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            n_fail++;
        end
    endtask : check
    task automatic tmo(input int n);
        if (n >= 40) begin
            n_fail++;
            give_verdict();
        end
    endtask : tmo
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && n < 40);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        tmo(n);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && n < 40);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        tmo(n);
    endtask : rd
    function automatic logic [8:0] exp_lamps(input logic [3:0] s);
        case (s)
            4'h0: return 9'h100;
            4'h1: return 9'h048;
            4'h2: return 9'h018;
            4'h3: return 9'h080;
            4'h4: return 9'h028;
            4'h5: return 9'h00c;
            4'h6: return 9'h00b;
            4'h8: return 9'h001;
            default: return 9'h000;
        endcase
    endfunction : exp_lamps
    // skips absent plow and fog steps and wraps from the last step
    function automatic logic [3:0] nxt(input logic [3:0] s, input logic [3:0] c);
        logic [3:0] n;
        n = s;
        do n = (n == step_last) ? step_first : n + 4'h1;
        while ((!c[ctrl_plow_bit] && (n == step_first || n == step_plow_low))
            || (!c[ctrl_fog_bit] && n == step_fog));
        return n;
    endfunction : nxt
    // a button start runs only when every entry condition holds and no brake aborts it
    function automatic logic exp_start(input logic [9:0] v);
        return v[9] && !v[8] && v[7] && !v[6] && v[3] && !v[2] && v[1] && v[0];
    endfunction : exp_start
    task automatic wait_act();
        int n;
        n = 0;
        while (lamp_check_active !== 1'b1 && n < 40) begin
            @(posedge aclk);
            n++;
        end
        tmo(n);
    endtask : wait_act
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        logic [3:0] s;
        int dw;
        logic [9:0] v;
        void'($urandom(32'h7eef));
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(ctrl_off);
        check(d, 32'h1);
        rd(dwell_off);
        check(d, 32'h2);
        rd(8'h0c);
        check(r, resp_slverr);
        wr(status_off, 32'h0);
        check(r, resp_slverr);
        wr(dwell_off, 32'h0);
        rd(dwell_off);
        check(d, 32'h1);
        wr(dwell_off, 32'hb);
        rd(dwell_off);
        check(d, 32'ha);
        // a write with the low byte lane off leaves the dwell alone
        s_axi_wstrb <= 4'h0;
        wr(dwell_off, 32'h5);
        s_axi_wstrb <= 4'hf;
        check(r, resp_okay);
        rd(dwell_off);
        check(d, 32'ha);
        for (int k = 0; k < 5; k++) begin
            dw = 1 + $urandom % 3;
            wr(dwell_off, dw);
            wr(ctrl_off, {28'h0, cfg[k] & 4'hd});
            veh.set_sw(10'h28b);
            veh.set_sw(10'h283);
            wait_act();
            s = nxt(step_last, cfg[k]);
            repeat (5) @(posedge aclk);
            for (int i = 0; i < 12; i++) begin
                check(32'(lamp_force), exp_lamps(s));
                repeat (10 * dw) @(posedge aclk);
                s = nxt(s, cfg[k]);
            end
            veh.set_sw(ex[k]);
            repeat (3) @(posedge aclk);
            check({lamp_check_active, 22'h0, lamp_force}, 0);
            veh.set_sw(10'h283);
            repeat (3) @(posedge aclk);
        end
        for (int k = 0; k < 12; k++) begin
            v = k[0] ? (10'($urandom) | 10'h008) : bad[$urandom % 5];
            veh.set_sw(v);
            repeat (6) @(posedge aclk);
            check(lamp_check_active, exp_start(v));
            // a brake pulse ends any check that a random word let start
            veh.set_sw(10'h2c3);
            veh.set_sw(10'h283);
            repeat (3) @(posedge aclk);
        end
        wr(ctrl_off, 32'h3);
        veh.set_sw(10'h2b3);
        veh.set_sw(10'h2c3);
        repeat (6) @(posedge aclk);
        check(lamp_check_active, 0);
        veh.set_sw(10'h283);
        wait_act();
        veh.set_sw(10'h287);
        repeat (3) @(posedge aclk);
        check({lamp_check_active, 22'h0, lamp_force}, 0);
        // idle, first step without plow is 1, abort flag sticky
        rd(status_off);
        check(d, 32'h81);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(ctrl_off);
        check(d, 32'h1);
        rd(dwell_off);
        check(d, 32'h2);
        rd(status_off);
        check(d, 32'h1);
        give_verdict();
    end
endmodule : elc_sequencer_tb_top
`default_nettype wire

//--- verification/elc_vehicle_model.sv
// switch and sensor model standing at the far side of the lamp check sequencer
`timescale 1ns/1ps
`default_nettype none
module elc_vehicle_model (
    input wire logic aclk,
    output logic key_ign_acc,
    output logic key_off_crank,
    output logic park_brake_set,
    output logic service_brake,
    output logic cruise_on,
    output logic cruise_resume,
    output logic lamp_check_button,
    output logic lamp_switch_any_on,
    output logic inputs_status_good,
    output logic cruise_status_good
);
    // key in run, park brake set, all lamps off, all status good
    logic [9:0] sw_q = 10'h283;
    assign {key_ign_acc, key_off_crank, park_brake_set, service_brake, cruise_on,
        cruise_resume, lamp_check_button, lamp_switch_any_on, inputs_status_good,
        cruise_status_good} = sw_q;
    // contacts move just after an edge so the sequencer sees them one edge later
    task automatic set_sw(input logic [9:0] v);
        @(posedge aclk);
        sw_q <= v;
    endtask : set_sw
endmodule : elc_vehicle_model
`default_nettype wire
